// *** verilog/aux_consts.svh ***
// Purpose: Offsets, field positions, reset values and codes for the step config bank
// Assumes: 8-bit register address, 16-bit register data
// Notes: Included by the bank and its package users
`ifndef AUX_CONSTS_SVH
`define AUX_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AUX_STEP13_ADDR 8'hDD
`define AUX_STEP14_ADDR 8'hDE

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AUX_STEP13_RESET 16'h000D
`define AUX_STEP14_RESET 16'h000E

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define AUX_EN_BIT 15
`define AUX_GAIN_HI 14
`define AUX_GAIN_LO 13
`define AUX_NEG_BIT 4
`define AUX_POS_HI 3
`define AUX_POS_LO 0
`define AUX_WMASK 16'hE01F
`define AUX_POS_INTERNAL 4'h8
`define AUX_GAIN_CODE_X2 2'h1
`define AUX_STEP_NUM 4'hD
`define AUX_STEP_NEXT 4'hE

`endif

// *** verilog/aux_pkg.sv ***
// Purpose: Types shared by the step config bank
// Assumes: Constants come from aux_consts.svh
// Notes: Types only
package aux_pkg;

    // Decoded gain applied to the converter
    typedef enum logic [1:0] {
        AUX_GAIN_X1 = 2'h0,
        AUX_GAIN_X2 = 2'h1,
        AUX_GAIN_X4 = 2'h3
    } aux_gain_e;

    // Negative input source
    typedef enum logic [1:0] {
        AUX_NEG_GROUND = 2'h0,
        AUX_NEG_INPUT7 = 2'h1,
        AUX_NEG_AUTO = 2'h3
    } aux_neg_e;

    // Fields of one step configuration word
    typedef struct packed {
        logic enable;
        logic [1:0] gain;
        logic neg_sel;
        logic [3:0] pos_sel;
    } aux_step_s;

    // Routing handed to the converter front end
    typedef struct packed {
        logic convert;
        aux_gain_e gain;
        aux_neg_e neg_src;
        logic [3:0] pos_src;
        logic internal;
    } aux_route_s;

endpackage

// *** verilog/aux_step_reg.sv ***
// Purpose: One step configuration register with masked write and readback
// Assumes: Same clock as the bus; reset value given by parameter
// Notes: Reserved bits 12:5 are not stored and read as zero
`timescale 1ns/1ps
`default_nettype none
`include "aux_consts.svh"

module aux_step_reg import aux_pkg::*; #(
    parameter logic [15:0] RESET_VAL = `AUX_STEP13_RESET
) (
    input wire logic mclk, // Clock
    input wire logic rstn, // Async reset, low
    input wire logic wr_en, // Write this register
    input wire logic [15:0] wdata, // Write data
    output logic [15:0] value // Stored value
);

    logic [15:0] val_q;
    logic [15:0] val_d;

    // Next value: only writable bits take write data
    always_comb begin
        val_d = val_q;
        if (wr_en) begin
            val_d = wdata & `AUX_WMASK;
        end
    end

    // Register the value
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            val_q <= RESET_VAL;
        end else begin
            val_q <= val_d;
        end
    end

    assign value = val_q;

endmodule // aux_step_reg

`default_nettype wire

// *** verilog/aux_step_bank.sv ***
// Purpose: Step 13 and 14 configuration bank of the secondary converter B
// Assumes: Plain register port, read data one cycle after the strobe
// Notes: Sequencer asks for a step by number and gets the routing back
`timescale 1ns/1ps
`default_nettype none
`include "aux_consts.svh"

module aux_step_bank import aux_pkg::*; (
    input wire logic mclk, // Clock, 10 MHz
    input wire logic rstn, // Async reset, low
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after strobe
    input wire logic seq_req, // Sequencer asks for a step
    input wire logic [3:0] seq_step, // Step number asked for
    output aux_route_s route, // Routing for the step
    output logic route_valid, // Routing valid pulse
    output logic step_skip // Step disabled, skip it
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    localparam int NSTEP = 2;
    localparam logic [7:0] STEP_ADDR [NSTEP] = '{`AUX_STEP13_ADDR, `AUX_STEP14_ADDR};
    localparam logic [15:0] STEP_RST [NSTEP] = '{`AUX_STEP13_RESET, `AUX_STEP14_RESET};

    logic [15:0] step_val [NSTEP];
    logic [NSTEP-1:0] step_wr;
    logic [15:0] s13_val;
    logic [15:0] s14_val;

    // One register per step, each with its own write decode
    for (genvar gi = 0; gi < NSTEP; gi++) begin : g_step
        assign step_wr[gi] = reg_wr && (reg_addr == STEP_ADDR[gi]);
        aux_step_reg #(.RESET_VAL(STEP_RST[gi])) u_reg (
            .mclk(mclk),
            .rstn(rstn),
            .wr_en(step_wr[gi]),
            .wdata(reg_wdata),
            .value(step_val[gi])
        );
    end

    // Named views for the decode below and for the checks
    assign s13_val = step_val[0];
    assign s14_val = step_val[1];

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    // Unmapped addresses read zero, so software sees no stale data
    always_comb begin
        rdata_d = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `AUX_STEP13_ADDR: rdata_d = s13_val;
                `AUX_STEP14_ADDR: rdata_d = s14_val;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Registered so read data stand exactly one cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // Register port checks
    // ----------------------------------------
    logic foreign_addr;

    // Reads and writes outside the two steps must leave no trace
    assign foreign_addr = (reg_addr != `AUX_STEP13_ADDR) && (reg_addr != `AUX_STEP14_ADDR);

    sequence s_wr14_then_rd;
        reg_wr && reg_addr == `AUX_STEP14_ADDR ##1 reg_rd && reg_addr == `AUX_STEP14_ADDR;
    endsequence

    a_step13_write: assert property (@(posedge mclk) disable iff (!rstn)
        reg_wr && reg_addr == `AUX_STEP13_ADDR |=> s13_val == ($past(reg_wdata) & `AUX_WMASK))
        else $error("step 13 write not masked");

    a_read_step13: assert property (@(posedge mclk) disable iff (!rstn)
        reg_rd && reg_addr == `AUX_STEP13_ADDR |=> reg_rdata == $past(s13_val))
        else $error("step 13 readback wrong");

    a_read_idle: assert property (@(posedge mclk) disable iff (!rstn)
        !reg_rd || foreign_addr |=> reg_rdata == 16'h0000)
        else $error("read data not zero");

    a_foreign_write: assert property (@(posedge mclk) disable iff (!rstn)
        reg_wr && foreign_addr |=> $stable(s13_val) && $stable(s14_val))
        else $error("unmapped write changed a step");

    // ----------------------------------------
    // Field decode into converter routing
    // ----------------------------------------
    aux_step_s cfg;
    aux_route_s route_d;
    aux_route_s route_q;
    logic valid_d;
    logic valid_q;
    logic skip_d;
    logic skip_q;
    logic hit;

    // Select the step word asked for; other steps belong elsewhere
    always_comb begin
        hit = 1'b0;
        cfg = '0;
        if (seq_step == `AUX_STEP_NUM) begin
            hit = 1'b1;
            cfg = {s13_val[15:13], s13_val[4:0]};
        end else if (seq_step == `AUX_STEP_NEXT) begin
            hit = 1'b1;
            cfg = {s14_val[15:13], s14_val[4:0]};
        end
    end

    // Decode fields; a disabled step drives no conversion
    always_comb begin
        route_d = route_q;
        valid_d = 1'b0;
        skip_d = 1'b0;
        if (seq_req && hit) begin
            if (!cfg.enable) begin
                skip_d = 1'b1;
                route_d.convert = 1'b0;
            end else begin
                valid_d = 1'b1;
                route_d.convert = 1'b1;
                case (cfg.gain)
                    2'h0: route_d.gain = AUX_GAIN_X1;
                    `AUX_GAIN_CODE_X2: route_d.gain = AUX_GAIN_X2;
                    default: route_d.gain = AUX_GAIN_X4;
                endcase
                route_d.pos_src = cfg.pos_sel;
                route_d.internal = cfg.pos_sel[3];
                if (cfg.pos_sel >= `AUX_POS_INTERNAL) begin
                    route_d.neg_src = AUX_NEG_AUTO;
                end else if (cfg.neg_sel) begin
                    route_d.neg_src = AUX_NEG_INPUT7;
                end else begin
                    route_d.neg_src = AUX_NEG_GROUND;
                end
            end
        end
    end

    // Register routing and the two answer pulses
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            route_q <= '{convert: 1'b0, gain: AUX_GAIN_X1, neg_src: AUX_NEG_GROUND,
                         pos_src: 4'h0, internal: 1'b0};
            valid_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            route_q <= route_d;
            valid_q <= valid_d;
            skip_q <= skip_d;
        end
    end

    assign route = route_q;
    assign route_valid = valid_q;
    assign step_skip = skip_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_req13_off;
        seq_req && seq_step == `AUX_STEP_NUM && !s13_val[15];
    endsequence

    sequence s_req14_off;
        seq_req && seq_step == `AUX_STEP_NEXT && !s14_val[`AUX_EN_BIT];
    endsequence

    // Request kinds for the checks
    logic req13_on;
    logic req14_on;
    logic req_foreign;
    assign req13_on = seq_req && (seq_step == `AUX_STEP_NUM) && s13_val[`AUX_EN_BIT];
    assign req14_on = seq_req && (seq_step == `AUX_STEP_NEXT) && s14_val[`AUX_EN_BIT];
    assign req_foreign = seq_req && (seq_step != `AUX_STEP_NUM) && (seq_step != `AUX_STEP_NEXT);

    a_skip_disabled: assert property (@(posedge mclk) disable iff (!rstn)
        s_req13_off |=> step_skip && !route_valid && !route.convert)
        else $error("disabled step not skipped");

    a_enable_converts: assert property (@(posedge mclk) disable iff (!rstn)
        seq_req && seq_step == `AUX_STEP_NUM && s13_val[15] |=> route_valid && route.convert)
        else $error("enabled step not converted");

    a_gain_four: assert property (@(posedge mclk) disable iff (!rstn)
        seq_req && seq_step == `AUX_STEP_NUM && s13_val[15] && s13_val[14]
        |=> route.gain == AUX_GAIN_X4)
        else $error("gain code not four");

    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn)
        reg_rd |=> reg_rdata[12:5] == 8'h00)
        else $error("reserved bits nonzero");

    a_neg_auto: assert property (@(posedge mclk) disable iff (!rstn)
        seq_req && seq_step == `AUX_STEP_NUM && s13_val[15] && s13_val[3]
        |=> route.neg_src == AUX_NEG_AUTO)
        else $error("negative select not ignored");

    a_neg_input7: assert property (@(posedge mclk) disable iff (!rstn)
        seq_req && seq_step == `AUX_STEP_NUM && s13_val[15] && !s13_val[3] && s13_val[4]
        |=> route.neg_src == AUX_NEG_INPUT7)
        else $error("negative input seven wrong");

    a_pos_route: assert property (@(posedge mclk) disable iff (!rstn)
        seq_req && seq_step == `AUX_STEP_NUM && s13_val[15]
        |=> route.pos_src == $past(s13_val[3:0]) && route.internal == $past(s13_val[3]))
        else $error("positive input wrong");

    a_write_read: assert property (@(posedge mclk) disable iff (!rstn)
        s_wr14_then_rd |=> reg_rdata == ($past(reg_wdata, 2) & `AUX_WMASK))
        else $error("step 14 readback wrong");

    a_reset_value: assert property (@(posedge mclk)
        $rose(rstn) |-> s13_val == `AUX_STEP13_RESET)
        else $error("step 13 reset value wrong");

    a_reset_step14: assert property (@(posedge mclk)
        $rose(rstn) |-> s14_val == `AUX_STEP14_RESET)
        else $error("step 14 reset value wrong");

    a_reset_outputs: assert property (@(posedge mclk)
        $rose(rstn) |-> !route_valid && !step_skip && !route.convert && reg_rdata == 16'h0000)
        else $error("outputs not at rest after reset");

    a_gain_one: assert property (@(posedge mclk) disable iff (!rstn)
        req13_on && s13_val[14:13] == 2'h0 |=> route.gain == AUX_GAIN_X1)
        else $error("gain code one wrong");

    a_gain_two: assert property (@(posedge mclk) disable iff (!rstn)
        req13_on && s13_val[14:13] == 2'h1 |=> route.gain == AUX_GAIN_X2)
        else $error("gain code two wrong");

    a_neg_ground: assert property (@(posedge mclk) disable iff (!rstn)
        req13_on && !s13_val[3] && !s13_val[4] |=> route.neg_src == AUX_NEG_GROUND)
        else $error("negative ground wrong");

    a_internal_src: assert property (@(posedge mclk) disable iff (!rstn)
        req13_on && s13_val[3] |=> route.internal && route.pos_src >= 4'h8)
        else $error("internal source not flagged");

    a_step14_route: assert property (@(posedge mclk) disable iff (!rstn)
        req14_on |=> route_valid && route.convert && route.pos_src == $past(s14_val[3:0]))
        else $error("step 14 routing wrong");

    a_step14_neg: assert property (@(posedge mclk) disable iff (!rstn)
        req14_on && !s14_val[3] && !s14_val[4] |=> route.neg_src == AUX_NEG_GROUND)
        else $error("step 14 negative input wrong");

    a_step14_skip: assert property (@(posedge mclk) disable iff (!rstn)
        s_req14_off |=> step_skip && !route_valid && !route.convert)
        else $error("disabled step 14 not skipped");

    a_foreign_quiet: assert property (@(posedge mclk) disable iff (!rstn)
        req_foreign |=> !route_valid && !step_skip)
        else $error("foreign step answered");

    // Without a request nothing moves, so a stale route is never re-announced
    a_route_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !seq_req |=> !route_valid && !step_skip && $stable(route))
        else $error("routing moved with no request");

    a_pulse_excl: assert property (@(posedge mclk) disable iff (!rstn)
        !(route_valid && step_skip))
        else $error("valid and skip together");

endmodule // aux_step_bank

`default_nettype wire

// *** verification/test_aux_step_bank.sv ***
// Purpose: Self-checking bench for the step 13/14 configuration bank
// Assumes: Read data sampled mid-cycle after the edge that takes the strobe
// Notes: A write is never followed at once by a write, so strobes never collide
`timescale 1ns/1ps
`default_nettype none
`include "aux_consts.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module test_aux_step_bank import aux_pkg::*; ;
    logic mclk, rstn, reg_wr, reg_rd, seq_req, route_valid, step_skip;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rdv;
    logic [3:0] seq_step;
    aux_route_s route;
    int failures, n_tests;

    // ----------------------------------------
    // Clock, reset and device
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    aux_step_bank i_dut (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .seq_req(seq_req), .seq_step(seq_step), .route(route),
        .route_valid(route_valid), .step_skip(step_skip));

    // ----------------------------------------
    // Bus and sequencer tasks, entered just after a rising edge
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
        @(posedge mclk);
    endtask

    // Pulses are one cycle wide, so they are judged in that cycle only
    task automatic seq(input logic [3:0] s, input logic v, input logic k);
        seq_req <= 1'b1;
        seq_step <= s;
        @(posedge mclk);
        seq_req <= 1'b0;
        @(negedge mclk);
        `CHK(route_valid, v)
        `CHK(step_skip, k)
        @(posedge mclk);
    endtask

    task automatic print_verdict();
        $display("checks=%0d failures=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(`AUX_STEP13_ADDR, rdv);
        `CHK(rdv, 16'h000d)
        rd(`AUX_STEP14_ADDR, rdv);
        `CHK(rdv, 16'h000e)
        seq(4'hd, 1'b0, 1'b1);
        `CHK(route.convert, 1'b0)
    endtask

    // Reserved bits dropped; unmapped place neither stores nor disturbs
    task automatic t_reserved();
        wr(`AUX_STEP13_ADDR, 16'hffff);
        rd(`AUX_STEP13_ADDR, rdv);
        `CHK(rdv, 16'he01f)
        wr(8'hdf, 16'hffff);
        rd(8'hdf, rdv);
        `CHK(rdv, 16'h0000)
        rd(`AUX_STEP14_ADDR, rdv);
        `CHK(rdv, 16'h000e)
    endtask

    task automatic t_gain();
        aux_gain_e ge;
        for (int g = 0; g < 4; g++) begin
            ge = (g == 0) ? AUX_GAIN_X1 : (g == 1) ? AUX_GAIN_X2 : AUX_GAIN_X4;
            wr(`AUX_STEP13_ADDR, {1'b1, 2'(g), 8'h00, 1'b0, 4'h2});
            seq(4'hd, 1'b1, 1'b0);
            `CHK(route.gain, ge)
            `CHK(route.convert, 1'b1)
        end
    endtask

    // Every positive code with both negative settings
    task automatic t_inputs();
        aux_neg_e ne;
        for (int p = 0; p < 16; p++) begin
            for (int n = 0; n < 2; n++) begin
                ne = (p >= 8) ? AUX_NEG_AUTO : (n == 1) ? AUX_NEG_INPUT7 : AUX_NEG_GROUND;
                wr(`AUX_STEP13_ADDR, {1'b1, 2'b00, 8'h00, 1'(n), 4'(p)});
                seq(4'hd, 1'b1, 1'b0);
                `CHK(route.pos_src, 4'(p))
                `CHK(route.internal, 1'(p >= 8))
                `CHK(route.neg_src, ne)
            end
        end
    endtask

    // Disabled step skipped, foreign step number unanswered, next step works
    task automatic t_skip();
        wr(`AUX_STEP13_ADDR, 16'h2013);
        seq(4'hd, 1'b0, 1'b1);
        `CHK(route.convert, 1'b0)
        seq(4'h5, 1'b0, 1'b0);
        seq(4'he, 1'b0, 1'b1);
        wr(`AUX_STEP14_ADDR, 16'h8007);
        rd(`AUX_STEP14_ADDR, rdv);
        `CHK(rdv, 16'h8007)
        seq(4'he, 1'b1, 1'b0);
        `CHK(route.pos_src, 4'h7)
    endtask

    // Mid-run reset puts written steps and outputs back at rest
    task automatic t_rereset();
        wr(`AUX_STEP13_ADDR, 16'h8005);
        seq(4'hd, 1'b1, 1'b0);
        `CHK(route.convert, 1'b1)
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK(route.convert, 1'b0)
        `CHK(route_valid, 1'b0)
        rstn <= 1'b1;
        @(posedge mclk);
        rd(`AUX_STEP13_ADDR, rdv);
        `CHK(rdv, 16'h000d)
        rd(`AUX_STEP14_ADDR, rdv);
        `CHK(rdv, 16'h000e)
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        failures = 0;
        n_tests = 0;
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        seq_req = 1'b0;
        seq_step = 4'h0;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_reserved();
        t_gain();
        t_inputs();
        t_skip();
        t_rereset();
        print_verdict();
    end

    // A hang is cut short and counted as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        print_verdict();
    end
endmodule // test_aux_step_bank
`default_nettype wire
